/* File: hw/oscsw_consts.svh */
// register offsets, field positions, reset values and timing counts for the clock switch block
`ifndef OSCSW_CONSTS_SVH
`define OSCSW_CONSTS_SVH

`define OSCSW_OSC_CONTROL_OFS   12'h000
`define OSCSW_CLOCK_DIVISOR_OFS 12'h004
`define OSCSW_PLL_FEEDBACK_OFS  12'h008
`define OSCSW_RC_TUNING_OFS     12'h00C
`define OSCSW_UNLOCK_OFS        12'h010
`define OSCSW_STATUS_OFS        12'h014

`define OSCSW_UNLOCK_KEY1       16'h0046
`define OSCSW_UNLOCK_KEY2       16'h0057

`define OSCSW_SWREQ_BIT         0
`define OSCSW_SECEN_BIT         1
`define OSCSW_FAIL_BIT          3
`define OSCSW_LOCK_BIT          5
`define OSCSW_ROI_BIT           15
`define OSCSW_REDUCTION_ENABLE_BIT         11

`define OSCSW_CLOCK_DIVISOR_RST        16'h3040
`define OSCSW_PLL_FEEDBACK_RST        9'h030
`define OSCSW_SETTLE_CYC        4'hA
`define OSCSW_OST_CYC           16'h0400

`endif

/* File: hw/oscsw_pkg.sv */
// types for the clock switch block
package oscsw_pkg;
    typedef enum logic [4:0] {
        SW_IDLE   = 5'b00001,
        SW_START  = 5'b00010,
        SW_READY  = 5'b00100,
        SW_SETTLE = 5'b01000,
        SW_DONE   = 5'b10000
    } oscsw_state_t;

    typedef logic [2:0] oscsw_src_t;

    localparam oscsw_src_t SRC_FRC     = 3'h0;
    localparam oscsw_src_t SRC_FRC_PLL = 3'h1;
    localparam oscsw_src_t SRC_PRI     = 3'h2;
    localparam oscsw_src_t SRC_PRI_PLL = 3'h3;
    localparam oscsw_src_t SRC_SEC     = 3'h4;
    localparam oscsw_src_t SRC_LOW_POWER_RC    = 3'h5;
    localparam oscsw_src_t SRC_FRC16   = 3'h6;
    localparam oscsw_src_t SRC_FRCN    = 3'h7;
endpackage

/* File: hw/oscsw_divsel.sv */
// power-of-two divider select with a registered output ratio
`timescale 1ns/1ps
module oscsw_divsel (
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic [2:0] code,
    input  wire logic       top_is_256,
    output logic      [8:0] ratio_q
);
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ratio_q <= 9'h001;
        end else if (top_is_256 && code == 3'h7) begin
            ratio_q <= 9'h100;
        end else begin
            ratio_q <= 9'(9'h001 << code);
        end
    end
endmodule

/* File: hw/oscsw_top.sv */
// oscillator selection, clock switch sequencer and fail-safe monitor
// Contract
// - writing one to switch_request starts a switch; reads zero when done
// - secondary_osc_enable turns the secondary crystal oscillator on or off
// - with recover_on_irq, an interrupt clears reduction_enable and forces 1:1
// - reduction ratio applies only while reduction_enable is set
// - rc_postscaler divides fast rc by 1..64, code 111 by 256
// - pll_out_divider divides vco by 2, 4 or 8
// - pll_in_divider divides reference by field plus two
// - pll_multiplier is field plus two, reset value gives 50
// - rc_trim is six-bit signed tuning of the fast rc
// - unprogrammed switch_cfg_bit disables switching and fail-safe monitor
// - switching disabled: new source ignored, current source from reset config
// - switching disabled: switch_request ignored and reads zero
// - request with equal current and new source clears request, aborts
// - a valid switch clears pll lock and clock fail flags
// - start target oscillator, wait startup timer or pll lock
// - after ready, wait ten target clock cycles then change over
// - on completion clear request and copy new source to current
// - stop old source except needed low power rc or enabled secondary
// - processor keeps running throughout the switch
// - enabled monitor keeps low power rc running except in sleep
// - oscillator failure raises trap and falls back to fast rc
// - failure while on pll falls back to fast rc with pll
// - source codes 000 to 111 as enumerated
//
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "oscsw_consts.svh"
module oscsw_top #(
    parameter int OST_CYCLES = 1024
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hsel,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              switch_cfg_bit,
    input  wire oscsw_pkg::oscsw_src_t reset_source_cfg,
    input  wire logic              watchdog_on,
    input  wire logic              sleep_mode,
    input  wire logic              irq_pending,
    input  wire logic              pll_locked_in,
    input  wire logic              osc_fail_in,
    input  wire logic [7:0]        osc_running_in,
    input  wire logic              new_clk_tick,
    output logic      [7:0]        osc_enable,
    output oscsw_pkg::oscsw_src_t  sys_clk_select,
    output logic                   clock_fail_trap,
    output logic      [8:0]        rc_div_ratio,
    output logic      [8:0]        doze_ratio,
    output logic      [5:0]        rc_trim,
    output logic      [4:0]        pll_in_divider,
    output logic      [1:0]        pll_out_divider,
    output logic      [8:0]        pll_multiplier
);
    import oscsw_pkg::*;

    ////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic [7:0] run1_q;
    logic [7:0] run2_q;
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
            run1_q  <= 8'h00;
            run2_q  <= 8'h00;
        end else begin
            sync1_q <= {pll_locked_in, osc_fail_in, new_clk_tick, irq_pending, sleep_mode};
            sync2_q <= sync1_q;
            run1_q  <= osc_running_in;
            run2_q  <= run1_q;
        end
    end
    logic pll_lock_s;
    logic osc_fail_s;
    logic tick_s;
    logic irq_s;
    logic sleep_s;
    assign {pll_lock_s, osc_fail_s, tick_s, irq_s, sleep_s} = sync2_q;
    logic tick_prev_q;
    always_ff @(posedge sys_clk) begin
        if (!rst_b) tick_prev_q <= 1'b0;
        else tick_prev_q <= tick_s;
    end
    logic tick_edge;
    assign tick_edge = tick_s && !tick_prev_q;

    ////////////////////////////////////////////////////////////////
    // configuration capture after reset release
    logic       cfg_taken_q;
    logic       sw_allowed_q;
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cfg_taken_q  <= 1'b0;
            sw_allowed_q <= 1'b0;
        end else if (!cfg_taken_q) begin
            cfg_taken_q  <= 1'b1;
            sw_allowed_q <= !switch_cfg_bit;
        end
    end

    ////////////////////////////////////////////////////////////////
    // ahb-lite slave
    logic        wr_pend_q;
    logic [11:0] wr_addr_q;
    logic        rd_fire;
    logic [11:0] rd_addr;
    assign rd_fire   = hsel && hready && htrans[1] && !hwrite;
    assign rd_addr   = haddr[11:0];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
        end else begin
            wr_pend_q <= hsel && hready && htrans[1] && hwrite;
            wr_addr_q <= haddr[11:0];
        end
    end
    logic wr_ctl;
    logic wr_div;
    logic wr_fbd;
    logic wr_tun;
    logic wr_key;
    assign wr_ctl = wr_pend_q && wr_addr_q == `OSCSW_OSC_CONTROL_OFS;
    assign wr_div = wr_pend_q && wr_addr_q == `OSCSW_CLOCK_DIVISOR_OFS;
    assign wr_fbd = wr_pend_q && wr_addr_q == `OSCSW_PLL_FEEDBACK_OFS;
    assign wr_tun = wr_pend_q && wr_addr_q == `OSCSW_RC_TUNING_OFS;
    assign wr_key = wr_pend_q && wr_addr_q == `OSCSW_UNLOCK_OFS;

    ////////////////////////////////////////////////////////////////
    // unlock: key1 then key2, opens one osc_control write
    logic [1:0] key_q;
    always_ff @(posedge sys_clk) begin
        if (!rst_b) key_q <= 2'h0;
        else if (wr_key && hwdata[15:0] == `OSCSW_UNLOCK_KEY1) key_q <= 2'h1;
        else if (wr_key && key_q == 2'h1 && hwdata[15:0] == `OSCSW_UNLOCK_KEY2) key_q <= 2'h2;
        else if (wr_key || wr_ctl) key_q <= 2'h0;
    end
    logic ctl_open;
    assign ctl_open = wr_ctl && key_q == 2'h2;

    ////////////////////////////////////////////////////////////////
    // osc_control state
    oscsw_state_t state_q;
    oscsw_src_t   cur_src_q;
    oscsw_src_t   new_src_q;
    logic         req_q;
    logic         sec_en_q;
    logic         lock_q;
    logic         fail_q;
    logic         fail_prev_q;
    logic [3:0]   settle_q;
    logic [15:0]  ost_q;
    logic         fail_event;
    assign fail_event = sw_allowed_q && osc_fail_s && !fail_prev_q;
    always_ff @(posedge sys_clk) begin
        if (!rst_b) fail_prev_q <= 1'b0;
        else fail_prev_q <= osc_fail_s;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            new_src_q <= SRC_FRC;
            sec_en_q  <= 1'b0;
        end else if (!cfg_taken_q) begin
            new_src_q <= reset_source_cfg;
        end else if (ctl_open) begin
            // high byte selects, low byte controls; a write without the unlock is ignored
            new_src_q <= hwdata[10:8];
            sec_en_q  <= hwdata[`OSCSW_SECEN_BIT];
        end
    end

    logic valid_start;
    assign valid_start = state_q == SW_START && new_src_q != cur_src_q;

    // request set by software; held zero when disabled
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            req_q <= 1'b0;
        end else if (!sw_allowed_q) begin
            req_q <= 1'b0;
        end else if (ctl_open && hwdata[`OSCSW_SWREQ_BIT]) begin
            req_q <= 1'b1;
        end else if (state_q == SW_START && !valid_start) begin
            req_q <= 1'b0;
        end else if (state_q == SW_DONE) begin
            req_q <= 1'b0;
        end
    end

    logic target_ready;
    logic need_pll;
    logic is_xtal;
    assign need_pll = new_src_q == SRC_FRC_PLL || new_src_q == SRC_PRI_PLL;
    assign is_xtal  = new_src_q == SRC_PRI || new_src_q == SRC_PRI_PLL || new_src_q == SRC_SEC;
    // wait startup timer or pll lock
    assign target_ready = run2_q[new_src_q] && (!is_xtal || ost_q == 16'h0000)
                          && (!need_pll || pll_lock_s);

    // sequencer runs beside the cpu, never stalls it
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_q  <= SW_IDLE;
            settle_q <= 4'h0;
            ost_q    <= 16'h0000;
        end else begin
            case (state_q)
                SW_IDLE: begin
                    if (req_q && !fail_event) state_q <= SW_START;
                end
                SW_START: begin
                    ost_q   <= 16'(OST_CYCLES);
                    state_q <= valid_start ? SW_READY : SW_IDLE;
                end
                SW_READY: begin
                    if (ost_q != 16'h0000 && run2_q[new_src_q]) ost_q <= ost_q - 16'h0001;
                    settle_q <= 4'h0;
                    if (target_ready) state_q <= SW_SETTLE;
                end
                SW_SETTLE: begin
                    // ten cycles of the new clock
                    if (tick_edge) settle_q <= settle_q + 4'h1;
                    if (settle_q == `OSCSW_SETTLE_CYC) state_q <= SW_DONE;
                end
                SW_DONE: begin
                    state_q <= SW_IDLE;
                end
                default: begin
                    state_q <= SW_IDLE;
                end
            endcase
            if (fail_event) state_q <= SW_IDLE;
        end
    end

    // reset config shown; copy new to current; fail-safe fallback
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cur_src_q <= SRC_FRC;
        end else if (!cfg_taken_q) begin
            cur_src_q <= reset_source_cfg;
        end else if (fail_event) begin
            cur_src_q <= (cur_src_q == SRC_PRI_PLL || cur_src_q == SRC_FRC_PLL) ? SRC_FRC_PLL : SRC_FRC;
        end else if (state_q == SW_DONE) begin
            cur_src_q <= new_src_q;
        end
    end

    // clear lock and fail on valid start; a fail event wins over the fail clear
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            lock_q <= 1'b0;
            fail_q <= 1'b0;
        end else begin
            if (fail_event) fail_q <= 1'b1;
            else if (valid_start) fail_q <= 1'b0;
            if (valid_start) lock_q <= 1'b0;
            else lock_q <= pll_lock_s;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) clock_fail_trap <= 1'b0;
        else clock_fail_trap <= fail_event;
    end

    ////////////////////////////////////////////////////////////////
    // oscillator enables
    logic [7:0] en_d;
    logic       pll_on;
    always_comb begin
        en_d = 8'h00;
        en_d[cur_src_q] = 1'b1;
        if (state_q != SW_IDLE) en_d[new_src_q] = 1'b1;
        if (sec_en_q) en_d[SRC_SEC] = 1'b1;
        // low power rc for watchdog, or for monitor when not in sleep
        if ((watchdog_on || (sw_allowed_q && !sleep_s))) en_d[SRC_LOW_POWER_RC] = 1'b1;
        pll_on = en_d[SRC_FRC_PLL] || en_d[SRC_PRI_PLL];
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            osc_enable     <= 8'h00;
            sys_clk_select <= SRC_FRC;
        end else begin
            osc_enable     <= en_d;
            sys_clk_select <= cur_src_q;
        end
    end

    ////////////////////////////////////////////////////////////////
    // clock_divisor, pll_feedback, rc_tuning
    logic       roi_q;
    logic       reduction_enable_q;
    logic [2:0] doze_q;
    logic [2:0] rc_postscaler_q;
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            roi_q           <= 1'b0;
            doze_q          <= 3'(`OSCSW_CLOCK_DIVISOR_RST >> 12);
            rc_postscaler_q        <= 3'h0;
            pll_out_divider <= 2'(`OSCSW_CLOCK_DIVISOR_RST >> 6);
            pll_in_divider  <= 5'h00;
        end else if (wr_div) begin
            roi_q           <= hwdata[`OSCSW_ROI_BIT];
            doze_q          <= hwdata[14:12];
            rc_postscaler_q        <= hwdata[10:8];
            pll_out_divider <= hwdata[7:6];
            pll_in_divider  <= hwdata[4:0];
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            reduction_enable_q <= 1'b0;
        end else if (roi_q && irq_s) begin
            reduction_enable_q <= 1'b0;
        end else if (wr_div) begin
            reduction_enable_q <= hwdata[`OSCSW_REDUCTION_ENABLE_BIT];
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pll_multiplier <= `OSCSW_PLL_FEEDBACK_RST;
            rc_trim        <= 6'h00;
        end else begin
            if (wr_fbd) pll_multiplier <= hwdata[8:0];
            if (wr_tun) rc_trim <= hwdata[5:0];
        end
    end

    // doze ratio applies only while enabled
    oscsw_divsel u_doze (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .code       (reduction_enable_q ? doze_q : 3'h0),
        .top_is_256 (1'b0),
        .ratio_q    (doze_ratio)
    );
    oscsw_divsel u_frc (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .code       (rc_postscaler_q),
        .top_is_256 (1'b1),
        .ratio_q    (rc_div_ratio)
    );

    ////////////////////////////////////////////////////////////////
    // read data
    logic [31:0] rd_d;
    always_comb begin
        rd_d = 32'h0000_0000;
        case (rd_addr)
            `OSCSW_OSC_CONTROL_OFS:   rd_d = {17'h0, cur_src_q, 1'b0, new_src_q, 2'h0, lock_q, 1'b0,
                                              fail_q, 1'b0, sec_en_q, req_q};
            `OSCSW_CLOCK_DIVISOR_OFS: rd_d = {16'h0, roi_q, doze_q, reduction_enable_q, rc_postscaler_q, pll_out_divider,
                                              1'b0, pll_in_divider};
            `OSCSW_PLL_FEEDBACK_OFS:  rd_d = {23'h0, pll_multiplier};
            `OSCSW_RC_TUNING_OFS:     rd_d = {26'h0, rc_trim};
            `OSCSW_STATUS_OFS:        rd_d = {24'h0, pll_on, sw_allowed_q, key_q, state_q[4:1]};
            default:                  rd_d = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_b) hrdata <= 32'h0000_0000;
        else if (rd_fire) hrdata <= rd_d;
    end

    ////////////////////////////////////////////////////////////////
    // checks
    disabled_req_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !sw_allowed_q |-> !req_q) else $error("request set while switching disabled");
    abort_equal_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (state_q == SW_START && new_src_q == cur_src_q && !fail_event) |=> !req_q)
        else $error("redundant switch not aborted");
    done_copy_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (state_q == SW_DONE && !fail_event) |=> (cur_src_q == $past(new_src_q) && !req_q))
        else $error("completion did not copy source");
    start_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (valid_start && !fail_event) |=> (!lock_q && !fail_q)) else $error("flags not cleared");
    roi_doze_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (roi_q && irq_s) |=> !reduction_enable_q ##2 doze_ratio == 9'h001) else $error("doze not recovered");
    fail_trap_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        fail_event |=> (clock_fail_trap && (cur_src_q == SRC_FRC || cur_src_q == SRC_FRC_PLL)))
        else $error("fail-safe fallback missing");
    settle_ten_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (state_q == SW_SETTLE && $past(state_q) == SW_READY) |-> settle_q == 4'h0)
        else $error("settle count not restarted");
    low_power_rc_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (sw_allowed_q && !sleep_s) |=> osc_enable[SRC_LOW_POWER_RC]) else $error("low power rc stopped");
    lock_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (wr_ctl && key_q != 2'h2 && cfg_taken_q) |=> $stable(new_src_q)) else $error("locked write took");
endmodule

/* File: test/oscsw_osc_model.sv */
// stand-in for the oscillators and pll on the far side of the clock switch block
`timescale 1ns/1ps
module oscsw_osc_model (
    input  wire logic       sys_clk,
    input  wire logic [7:0] osc_enable,
    input  wire logic       fail_cmd,
    output logic      [7:0] osc_running_in,
    output logic            pll_locked_in,
    output logic            osc_fail_in,
    output logic            new_clk_tick
);
    logic [3:0] age_q [8];
    // only the tick needs a start value; the rest settles while the block is in reset
    logic [1:0] tick_q = 2'h0;
    // sources start several cycles late, the pll later still
    always @(posedge sys_clk) begin
        for (int i = 0; i < 8; i++) begin
            age_q[i] <= osc_enable[i] ? ((age_q[i] == 4'hF) ? age_q[i] : age_q[i] + 4'h1) : 4'h0;
            osc_running_in[i] <= osc_enable[i] && (age_q[i] > 4'h5);
        end
        pll_locked_in <= (osc_enable[1] && age_q[1] > 4'h9) || (osc_enable[3] && age_q[3] > 4'h9);
        tick_q <= tick_q + 2'h1;
    end
    // no target clock when nothing is enabled
    assign new_clk_tick = (|osc_enable) & tick_q[1];
    assign osc_fail_in = fail_cmd;
endmodule

/* File: test/osc_select_switch_failsafe_tb.sv */
// self-checking bench for the clock switch block
`timescale 1ns/1ps
`include "oscsw_consts.svh"
module osc_select_switch_failsafe_tb;
    import oscsw_pkg::*;
    logic sys_clk, rst_b, hwrite, hreadyout, hresp, switch_cfg_bit, irq_pending, fail_cmd, pll_locked_in;
    logic osc_fail_in, new_clk_tick, clock_fail_trap, sleep_mode;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0]  htrans, pll_out_divider;
    logic [7:0]  osc_running_in, osc_enable;
    logic [8:0]  rc_div_ratio, doze_ratio, pll_multiplier;
    logic [5:0]  rc_trim;
    logic [4:0]  pll_in_divider;
    logic [15:0] v;
    oscsw_src_t  reset_source_cfg, sys_clk_select;
    int          err_count, cmp_count, seen;
    oscsw_top #(.OST_CYCLES(4)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hsel(1'b1), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .switch_cfg_bit(switch_cfg_bit),
        .reset_source_cfg(reset_source_cfg), .watchdog_on(1'b0), .sleep_mode(sleep_mode), .irq_pending(irq_pending),
        .pll_locked_in(pll_locked_in), .osc_fail_in(osc_fail_in), .osc_running_in(osc_running_in),
        .new_clk_tick(new_clk_tick), .osc_enable(osc_enable), .sys_clk_select(sys_clk_select),
        .clock_fail_trap(clock_fail_trap), .rc_div_ratio(rc_div_ratio), .doze_ratio(doze_ratio),
        .rc_trim(rc_trim), .pll_in_divider(pll_in_divider), .pll_out_divider(pll_out_divider),
        .pll_multiplier(pll_multiplier));
    oscsw_osc_model osc_u (.sys_clk(sys_clk), .osc_enable(osc_enable), .fail_cmd(fail_cmd),
        .osc_running_in(osc_running_in), .pll_locked_in(pll_locked_in), .osc_fail_in(osc_fail_in),
        .new_clk_tick(new_clk_tick));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // one transfer; caller sits just after a rising edge
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        haddr <= {20'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        logic [31:0] x;
        bus(1'b1, a, {16'h0, d}, x);
    endtask
    task automatic unlock();
        wr(`OSCSW_UNLOCK_OFS, `OSCSW_UNLOCK_KEY1);
        wr(`OSCSW_UNLOCK_OFS, `OSCSW_UNLOCK_KEY2);
    endtask
    // unlock, select, unlock, request; then poll the request bit
    task automatic do_sw(input oscsw_src_t t);
        unlock();
        wr(`OSCSW_OSC_CONTROL_OFS, {5'h0, t, 8'h00});
        unlock();
        wr(`OSCSW_OSC_CONTROL_OFS, {5'h0, t, 8'h01});
        r = 32'h1;
        for (int n = 0; n < 300 && r[0] !== 1'b0; n++) bus(1'b0, `OSCSW_OSC_CONTROL_OFS, 32'h0, r);
        chk("switch_request", 32'h0, {31'h0, r[0]});
        chk("current_source", {29'h0, t}, {29'h0, r[14:12]});
        chk("sys_clk_select", {29'h0, t}, {29'h0, sys_clk_select});
        chk("clock_fail_flag", 32'h0, {31'h0, r[3]});
    endtask
    // raise the failure pin for 30 cycles, expect at least one trap and the fallback source e
    task automatic fail_chk(input oscsw_src_t e);
        seen = 0;
        fail_cmd <= 1'b1;
        for (int n = 0; n < 30; n++) begin
            @(posedge sys_clk);
            if (clock_fail_trap === 1'b1) seen = 1;
        end
        fail_cmd <= 1'b0;
        chk("clock_fail_trap", 32'h1, seen);
        bus(1'b0, `OSCSW_OSC_CONTROL_OFS, 32'h0, r);
        chk("clock_fail_flag", 32'h1, {31'h0, r[3]});
        chk("fallback_select", {29'h0, e}, {29'h0, sys_clk_select});
    endtask
    function automatic logic [31:0] exp_rc(input logic [2:0] c);
        return (c == 3'h7) ? 32'd256 : (32'd1 << c);
    endfunction
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        #2_000_000;
        err_count++;
        end_sim();
    end
    initial begin
        err_count = 0; cmp_count = 0; rst_b = 1'b0; switch_cfg_bit = 1'b1; reset_source_cfg = SRC_PRI; sleep_mode = 1'b0;
        haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0; irq_pending = 1'b0; fail_cmd = 1'b0;
        void'($urandom(32'hfb4e8654));
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge sys_clk);
        bus(1'b0, `OSCSW_CLOCK_DIVISOR_OFS, 32'h0, r);
        chk("clock_divisor", {16'h0, `OSCSW_CLOCK_DIVISOR_RST}, r);
        bus(1'b0, `OSCSW_PLL_FEEDBACK_OFS, 32'h0, r);
        chk("pll_feedback", 32'h30, r);
        bus(1'b0, 12'h100, 32'h0, r);
        chk("unmapped", 32'h0, r);
        // switching locked out by the config bit
        unlock();
        wr(`OSCSW_OSC_CONTROL_OFS, {5'h0, SRC_SEC, 8'h01});
        repeat (40) @(posedge sys_clk);
        bus(1'b0, `OSCSW_OSC_CONTROL_OFS, 32'h0, r);
        chk("locked_request", 32'h0, {31'h0, r[0]});
        chk("locked_current", {29'h0, SRC_PRI}, {29'h0, r[14:12]});
        chk("locked_select", {29'h0, SRC_PRI}, {29'h0, sys_clk_select});
        rst_b <= 1'b0;
        switch_cfg_bit <= 1'b0;
        reset_source_cfg <= SRC_FRC;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge sys_clk);
        wr(`OSCSW_OSC_CONTROL_OFS, {5'h0, SRC_PRI, 8'h00});
        bus(1'b0, `OSCSW_OSC_CONTROL_OFS, 32'h0, r);
        chk("unkeyed_write", 32'h0, {29'h0, r[10:8]});
        do_sw(SRC_FRC);
        do_sw(SRC_PRI);
        fail_chk(SRC_FRC);
        // pll modes reached through plain fast rc only
        do_sw(SRC_FRC_PLL);
        do_sw(SRC_FRC);
        do_sw(SRC_PRI_PLL);
        for (int i = 0; i < 8; i++) begin
            v = 16'($urandom);
            v = {1'b0, 3'(7 - i), v[11], 3'(i), v[7:6] == 2'h2 ? 2'h1 : v[7:6], 1'b0, v[4:0]};
            wr(`OSCSW_CLOCK_DIVISOR_OFS, v);
            repeat (4) @(posedge sys_clk);
            chk("doze_ratio", v[11] ? 32'h1 << (7 - i) : 32'h1, {23'h0, doze_ratio});
            chk("rc_div_ratio", exp_rc(3'(i)), {23'h0, rc_div_ratio});
            chk("pll_out_divider", {30'h0, v[7:6]}, {30'h0, pll_out_divider});
            chk("pll_in_divider", {27'h0, v[4:0]}, {27'h0, pll_in_divider});
            v = (i == 0) ? 16'h01FF : 16'($urandom);
            wr(`OSCSW_PLL_FEEDBACK_OFS, {7'h0, v[8:0]});
            wr(`OSCSW_RC_TUNING_OFS, (i == 0) ? 16'h0020 : {10'h0, v[5:0]});
            repeat (2) @(posedge sys_clk);
            chk("pll_multiplier", {23'h0, v[8:0]}, {23'h0, pll_multiplier});
            chk("rc_trim", (i == 0) ? 32'h20 : {26'h0, v[5:0]}, {26'h0, rc_trim});
        end
        wr(`OSCSW_CLOCK_DIVISOR_OFS, 16'hB800);
        irq_pending <= 1'b1;
        repeat (3) @(posedge sys_clk);
        irq_pending <= 1'b0;
        repeat (6) @(posedge sys_clk);
        bus(1'b0, `OSCSW_CLOCK_DIVISOR_OFS, 32'h0, r);
        chk("reduction_enable", 32'h0, {31'h0, r[11]});
        chk("doze_after_irq", 32'h1, {23'h0, doze_ratio});
        // failure on the primary with pll falls back to fast rc with pll
        fail_chk(SRC_FRC_PLL);
        // monitor's low power rc rests only in sleep
        sleep_mode <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk("low_power_rc_sleep", 32'h0, {31'h0, osc_enable[SRC_LOW_POWER_RC]});
        sleep_mode <= 1'b0;
        repeat (6) @(posedge sys_clk);
        chk("low_power_rc_awake", 32'h1, {31'h0, osc_enable[SRC_LOW_POWER_RC]});
        end_sim();
    end
endmodule
